// ===== pkg/dlx_pkg.sv
// package: constants and types for the disk link exchange checker
package dlx_pkg;
	// retry budgets
	localparam logic [3:0] INIT_RETRY_MAX = 4'h8;
	localparam logic [3:0] TIMEOUT_RETRY_MAX = 4'h3;
	localparam logic [3:0] QUERY_RETRY_MAX = 4'h2;
	localparam logic [3:0] ROUND_MAX = 4'h2;
	localparam logic [3:0] PULSE_RETRY_MAX = 4'h2;
	// response buffer depth in frames
	localparam logic [7:0] RESP_DEPTH = 8'h10;
	// default timeouts in controller clocks
	localparam int EXCH_TIMEOUT_DEF = 20000;
	localparam int CLK_WAIT_DEF = 20000;
	// error flag positions
	localparam int ERR_COLLIDE = 0;
	localparam int ERR_LENOP = 1;
	localparam int ERR_OVERFLOW = 2;
	localparam int ERR_TIMEOUT = 3;
	localparam int ERR_CLK_PERSIST = 4;
	localparam int ERR_CLK_RESUME = 5;
	localparam int ERR_PULSE = 6;
	localparam int ERR_W = 7;

	typedef enum logic [2:0] {
		DLX_ACT_NONE,
		DLX_ACT_RETRY,
		DLX_ACT_QUERY,
		DLX_ACT_INIT,
		DLX_ACT_DEAD
	} dlx_action_t;

	// one received response frame, as judged by the link logic
	typedef struct packed {
		logic valid;
		logic last;
		logic frame_ok;
		logic opcode_ok;
		logic length_ok;
		logic context_ok;
	} dlx_frame_t;
endpackage : dlx_pkg

// ===== verilog/dlx_checker.sv
// module: exchange checker and retry sequencer for a serial disk link
//
// Contract
// [RULE1] after command, raise own ready, await response
// [RULE2] drive drops ready, re-raises after response
// [RULE3] flag collision: no drop, or early re-raise
// [RULE4] well framed illegal response flags length/opcode
// [RULE5] flag overflow when frames exceed buffer
// [RULE6] timeout on exchange or seek ready wait
// [RULE7] clock persists after init: retry eight times
// [RULE8] clock fails to resume: report failure
// [RULE9] timeout: retry three times with reinit
// [RULE10] collision/lenop: query, clear, retry; escalate
// [RULE11] pulse/parity: query, clear, retry twice
// [RULE12] sticky per-fault flags until processor clears
`timescale 1ns/1ps
`default_nettype none
module dlx_checker #(
	parameter int EXCH_TIMEOUT = dlx_pkg::EXCH_TIMEOUT_DEF,
	parameter int CLK_WAIT = dlx_pkg::CLK_WAIT_DEF
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic drive_clk,
	input wire logic cmd_sent,
	input wire logic cmd_is_seek,
	input wire logic init_sent,
	input wire logic drive_rdy,
	input wire logic rw_ready,
	input wire logic pulse_err,
	input wire dlx_pkg::dlx_frame_t frame_in,
	input wire logic [dlx_pkg::ERR_W-1:0] err_clear,
	output logic ctrl_rdy,
	output logic [dlx_pkg::ERR_W-1:0] err_flags,
	output dlx_pkg::dlx_action_t action,
	output logic action_stb,
	output logic drive_dead
);
	// ====================================================================
	// link domain: count frames and judge them on the drive clock
	// ====================================================================
	logic [7:0] lk_cnt_q, lk_cnt_d;
	logic lk_bad_q, lk_bad_d, lk_ovf_q, lk_ovf_d, lk_done_q, lk_done_d;
	logic lk_tog_q, lk_tog_d, lk_beat_q, lk_beat_d;
	logic [2:0] arm_sync_q;
	logic arm_q, arm_d;

	always_comb begin
		lk_cnt_d = lk_cnt_q;
		lk_bad_d = lk_bad_q;
		lk_ovf_d = lk_ovf_q;
		lk_done_d = lk_done_q;
		lk_tog_d = lk_tog_q;
		lk_beat_d = ~lk_beat_q;
		// new command arms a fresh count; edge of the synchronised toggle
		if (arm_sync_q[2] != arm_sync_q[1]) begin
			lk_cnt_d = 8'h00;
			lk_bad_d = 1'b0;
			lk_ovf_d = 1'b0;
			lk_done_d = 1'b0;
		end else if (frame_in.valid && frame_in.frame_ok) begin
			if (lk_cnt_q >= dlx_pkg::RESP_DEPTH)
				lk_ovf_d = 1'b1; // RULE5
			else
				lk_cnt_d = lk_cnt_q + 8'h01;
			if (!frame_in.opcode_ok || !frame_in.length_ok || !frame_in.context_ok)
				lk_bad_d = 1'b1; // RULE4
			if (frame_in.last && !lk_done_q) begin
				lk_done_d = 1'b1;
				lk_tog_d = ~lk_tog_q;
			end
		end
	end

	always_ff @(posedge drive_clk or posedge rst) begin
		if (rst) begin
			lk_cnt_q <= 8'h00;
			lk_bad_q <= 1'b0;
			lk_ovf_q <= 1'b0;
			lk_done_q <= 1'b0;
			lk_tog_q <= 1'b0;
			lk_beat_q <= 1'b0;
			arm_sync_q <= 3'b000;
		end else begin
			lk_cnt_q <= lk_cnt_d;
			lk_bad_q <= lk_bad_d;
			lk_ovf_q <= lk_ovf_d;
			lk_done_q <= lk_done_d;
			lk_tog_q <= lk_tog_d;
			lk_beat_q <= lk_beat_d;
			arm_sync_q <= {arm_sync_q[1:0], arm_q};
		end
	end

	// ====================================================================
	// controller domain: synchronisers
	// ====================================================================
	logic [2:0] tog_s_q, beat_s_q;
	logic [1:0] rdy_s_q, rw_s_q;
	logic [2:0] pe_s_q;
	logic [1:0] bad_s_q, ovf_s_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tog_s_q <= 3'b000;
			beat_s_q <= 3'b000;
			rdy_s_q <= 2'b00;
			rw_s_q <= 2'b00;
			pe_s_q <= 3'b000;
			bad_s_q <= 2'b00;
			ovf_s_q <= 2'b00;
		end else begin
			tog_s_q <= {tog_s_q[1:0], lk_tog_q};
			beat_s_q <= {beat_s_q[1:0], lk_beat_q};
			rdy_s_q <= {rdy_s_q[0], drive_rdy};
			rw_s_q <= {rw_s_q[0], rw_ready};
			pe_s_q <= {pe_s_q[1:0], pulse_err};
			// bad/overflow are stable once the done toggle has crossed
			bad_s_q <= {bad_s_q[0], lk_bad_q};
			ovf_s_q <= {ovf_s_q[0], lk_ovf_q};
		end
	end

	logic resp_done, clk_alive, d_rdy;
	assign resp_done = tog_s_q[2] != tog_s_q[1];
	assign clk_alive = beat_s_q[2] != beat_s_q[1];
	assign d_rdy = rdy_s_q[1];

	// ====================================================================
	// exchange watcher and retry sequencer
	// ====================================================================
	typedef enum logic [2:0] {
		ST_IDLE, ST_WAIT_DROP, ST_WAIT_RESP, ST_WAIT_SEEK, ST_CLK_STOP, ST_CLK_RESUME
	} dlx_state_t;

	dlx_state_t st_q, st_d;
	logic [31:0] tmr_q, tmr_d;
	logic [3:0] init_n_q, init_n_d, to_n_q, to_n_d, qr_n_q, qr_n_d, rnd_q, rnd_d, pe_n_q, pe_n_d;
	logic seek_q, seek_d, rdy_q, rdy_d, dead_q, dead_d, stb_q, stb_d, seen_q, seen_d;
	logic [dlx_pkg::ERR_W-1:0] err_q, err_d, ev;
	dlx_pkg::dlx_action_t act_q, act_d;

	always_comb begin
		st_d = st_q;
		tmr_d = tmr_q + 32'h1;
		init_n_d = init_n_q;
		to_n_d = to_n_q;
		qr_n_d = qr_n_q;
		rnd_d = rnd_q;
		pe_n_d = pe_n_q;
		seek_d = seek_q;
		rdy_d = rdy_q;
		arm_d = arm_q;
		dead_d = dead_q;
		seen_d = seen_q;
		act_d = act_q;
		stb_d = 1'b0;
		ev = '0;
		if (pe_s_q[1] && !pe_s_q[2])
			ev[dlx_pkg::ERR_PULSE] = 1'b1;
		unique case (st_q)
			ST_IDLE: begin
				if (init_sent) begin
					st_d = ST_CLK_STOP;
					tmr_d = 32'h0;
				end else if (cmd_sent && !dead_q) begin
					rdy_d = 1'b1; // RULE1
					arm_d = ~arm_q;
					seek_d = cmd_is_seek;
					st_d = ST_WAIT_DROP;
					tmr_d = 32'h0;
				end
			end
			ST_WAIT_DROP: begin
				if (!d_rdy)
					st_d = ST_WAIT_RESP; // RULE2
				else if (tmr_q >= 32'(EXCH_TIMEOUT))
					ev[dlx_pkg::ERR_COLLIDE] = 1'b1; // RULE3
			end
			ST_WAIT_RESP: begin
				if (resp_done) begin
					rdy_d = 1'b0;
					ev[dlx_pkg::ERR_OVERFLOW] = ovf_s_q[1];
					ev[dlx_pkg::ERR_LENOP] = bad_s_q[1];
					st_d = seek_q ? ST_WAIT_SEEK : ST_IDLE;
					tmr_d = 32'h0;
				end else if (d_rdy)
					ev[dlx_pkg::ERR_COLLIDE] = 1'b1; // RULE3
				else if (tmr_q >= 32'(EXCH_TIMEOUT))
					ev[dlx_pkg::ERR_TIMEOUT] = 1'b1; // RULE6
			end
			ST_WAIT_SEEK: begin
				if (rw_s_q[1])
					st_d = ST_IDLE;
				else if (tmr_q >= 32'(EXCH_TIMEOUT))
					ev[dlx_pkg::ERR_TIMEOUT] = 1'b1; // RULE6
			end
			ST_CLK_STOP: begin
				// early beats are the drive winding down; a late one means init was missed
				seen_d = (tmr_q >= 32'(CLK_WAIT / 2)) && (seen_q || clk_alive);
				if (tmr_q >= 32'(CLK_WAIT)) begin
					st_d = ST_CLK_RESUME;
					tmr_d = 32'h0;
					if (seen_q)
						ev[dlx_pkg::ERR_CLK_PERSIST] = 1'b1; // RULE7
				end
			end
			ST_CLK_RESUME: begin
				if (clk_alive) begin
					st_d = ST_IDLE;
					init_n_d = 4'h0;
				end else if (tmr_q >= 32'(CLK_WAIT))
					ev[dlx_pkg::ERR_CLK_RESUME] = 1'b1; // RULE8
			end
		endcase
		// escalation: one action per cycle with any detected event, back to idle
		if (ev != '0) begin
			st_d = ST_IDLE;
			rdy_d = 1'b0;
			stb_d = 1'b1;
			if (ev[dlx_pkg::ERR_CLK_PERSIST] || ev[dlx_pkg::ERR_CLK_RESUME]) begin
				init_n_d = init_n_q + 4'h1;
				act_d = (init_n_q >= dlx_pkg::INIT_RETRY_MAX) ? dlx_pkg::DLX_ACT_DEAD
					: dlx_pkg::DLX_ACT_INIT; // RULE7
			end else if (ev[dlx_pkg::ERR_TIMEOUT]) begin
				to_n_d = to_n_q + 4'h1;
				act_d = (to_n_q >= dlx_pkg::TIMEOUT_RETRY_MAX) ? dlx_pkg::DLX_ACT_DEAD
					: dlx_pkg::DLX_ACT_INIT; // RULE9
			end else if (ev[dlx_pkg::ERR_COLLIDE] || ev[dlx_pkg::ERR_LENOP]) begin
				act_d = dlx_pkg::DLX_ACT_QUERY; // RULE10
				qr_n_d = qr_n_q + 4'h1;
				if (qr_n_q >= dlx_pkg::QUERY_RETRY_MAX) begin
					qr_n_d = 4'h0;
					rnd_d = rnd_q + 4'h1;
					act_d = (rnd_q >= dlx_pkg::ROUND_MAX) ? dlx_pkg::DLX_ACT_DEAD
						: dlx_pkg::DLX_ACT_INIT; // RULE10
				end
			end else if (ev[dlx_pkg::ERR_PULSE]) begin
				pe_n_d = pe_n_q + 4'h1;
				act_d = (pe_n_q >= dlx_pkg::PULSE_RETRY_MAX) ? dlx_pkg::DLX_ACT_DEAD
					: dlx_pkg::DLX_ACT_QUERY; // RULE11
			end else
				act_d = dlx_pkg::DLX_ACT_RETRY;
			if (act_d == dlx_pkg::DLX_ACT_DEAD)
				dead_d = 1'b1;
		end else if (st_q == ST_WAIT_RESP && resp_done && !seek_q) begin
			to_n_d = 4'h0;
			qr_n_d = 4'h0;
			rnd_d = 4'h0;
			pe_n_d = 4'h0;
		end
		// set wins over clear
		err_d = (err_q & ~err_clear) | ev; // RULE12
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= ST_IDLE;
			tmr_q <= 32'h0;
			init_n_q <= 4'h0;
			to_n_q <= 4'h0;
			qr_n_q <= 4'h0;
			rnd_q <= 4'h0;
			pe_n_q <= 4'h0;
			seek_q <= 1'b0;
			rdy_q <= 1'b0;
			arm_q <= 1'b0;
			dead_q <= 1'b0;
			seen_q <= 1'b0;
			stb_q <= 1'b0;
			act_q <= dlx_pkg::DLX_ACT_NONE;
			err_q <= '0;
		end else begin
			st_q <= st_d;
			tmr_q <= tmr_d;
			init_n_q <= init_n_d;
			to_n_q <= to_n_d;
			qr_n_q <= qr_n_d;
			rnd_q <= rnd_d;
			pe_n_q <= pe_n_d;
			seek_q <= seek_d;
			rdy_q <= rdy_d;
			arm_q <= arm_d;
			dead_q <= dead_d;
			seen_q <= seen_d;
			stb_q <= stb_d;
			act_q <= act_d;
			err_q <= err_d;
		end
	end

	always_comb begin
		ctrl_rdy = rdy_q;
		err_flags = err_q;
		action = act_q;
		action_stb = stb_q;
		drive_dead = dead_q;
	end
endmodule : dlx_checker
`default_nettype wire

// ===== tb/dlx_checker_monitor.sv
// checker: port assertions for the exchange checker
`timescale 1ns/1ps
`default_nettype none
module dlx_checker_mon #(
	parameter int EXCH_TIMEOUT = dlx_pkg::EXCH_TIMEOUT_DEF,
	parameter int CLK_WAIT = dlx_pkg::CLK_WAIT_DEF
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic cmd_sent,
	input wire logic [dlx_pkg::ERR_W-1:0] err_clear,
	input wire logic ctrl_rdy,
	input wire logic [dlx_pkg::ERR_W-1:0] err_flags,
	input wire dlx_pkg::dlx_action_t action,
	input wire logic action_stb,
	input wire logic drive_dead
);
	// ====
	// properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_fault_act;
		action_stb && action inside {dlx_pkg::DLX_ACT_QUERY, dlx_pkg::DLX_ACT_INIT,
			dlx_pkg::DLX_ACT_DEAD};
	endsequence
	sequence s_reinit_act;
		action_stb && action inside {dlx_pkg::DLX_ACT_INIT, dlx_pkg::DLX_ACT_DEAD};
	endsequence
	chk_rdy_answer: assert property (cmd_sent && !ctrl_rdy && !drive_dead |=> ctrl_rdy)
		else $error("ctrl_rdy not raised after command");
	chk_flag_sticky: assert property (
		($past(err_flags) & ~err_flags & ~$past(err_clear)) == '0)
		else $error("error flag fell without clear");
	chk_collide_act: assert property ($rose(err_flags[dlx_pkg::ERR_COLLIDE]) |-> s_fault_act)
		else $error("collision without recovery action");
	chk_lenop_act: assert property ($rose(err_flags[dlx_pkg::ERR_LENOP]) |-> s_fault_act)
		else $error("length error without recovery action");
	chk_timeout_act: assert property ($rose(err_flags[dlx_pkg::ERR_TIMEOUT]) |-> s_reinit_act)
		else $error("timeout without reinit action");
	chk_timeout_rdy: assert property ($rose(err_flags[dlx_pkg::ERR_TIMEOUT]) |-> ##[0:2] !ctrl_rdy)
		else $error("ctrl_rdy held after timeout");
	chk_dead_sticky: assert property (drive_dead |=> drive_dead)
		else $error("drive_dead dropped");
	chk_dead_act: assert property (action_stb && action == dlx_pkg::DLX_ACT_DEAD |->
		##[0:1] drive_dead) else $error("dead action without drive_dead");
	chk_dead_refuse: assert property (drive_dead && cmd_sent |=> !ctrl_rdy)
		else $error("command taken while dead");
endmodule : dlx_checker_mon
bind dlx_checker dlx_checker_mon #(.EXCH_TIMEOUT(EXCH_TIMEOUT), .CLK_WAIT(CLK_WAIT)) u_mon (
	.clk(clk), .rst(rst), .cmd_sent(cmd_sent), .err_clear(err_clear), .ctrl_rdy(ctrl_rdy),
	.err_flags(err_flags), .action(action), .action_stb(action_stb), .drive_dead(drive_dead)
);
`default_nettype wire

// ===== tb/dlx_drive_model.sv
// partner: behavioural drive at the far end of the link
`timescale 1ns/1ps
`default_nettype none
module dlx_drive_model (
	input wire logic rst,
	input wire logic go,
	input wire logic [1:0] mode,
	input wire logic [4:0] nfr,
	input wire logic bad,
	input wire logic run,
	output logic drive_clk,
	output logic drive_rdy,
	output dlx_pkg::dlx_frame_t frame_in
);
	// ====
	// link side
	logic busy;
	logic [4:0] n;
	logic [1:0] lead;
	// clock parks low when stopped, as a drive does after init
	initial drive_clk = 1'b0;
	always #40 drive_clk = (run || drive_clk) ? ~drive_clk : 1'b0;
	always @(posedge drive_clk or posedge rst) begin
		if (rst) begin
			busy <= 1'b0;
			n <= 5'h00;
			lead <= 2'h0;
			drive_rdy <= 1'b1;
			frame_in <= '0;
		end else begin
			frame_in <= {1'b0, ~frame_in[4:0]};
			if (go && !busy) begin
				busy <= 1'b1;
				n <= 5'h00;
				lead <= 2'h0;
				drive_rdy <= (mode == 2'h1);
			end else if (busy && !go) begin
				busy <= 1'b0;
				drive_rdy <= 1'b1;
			end else if (busy && lead != 2'h3) begin
				// the checker's arm toggle needs a few beats to cross before frames count
				lead <= lead + 2'h1;
			end else if (busy && mode == 2'h0 && n <= nfr) begin
				// one idle beat after the last frame keeps ready behind the done flag
				if (n < nfr) frame_in <= {1'b1, n == nfr - 5'h01, 1'b1, !bad, 2'h3};
				n <= n + 5'h01;
			end else if (busy && mode == 2'h0) drive_rdy <= 1'b1;
		end
	end
endmodule : dlx_drive_model
`default_nettype wire

// ===== tb/tb_disk_link_exchange_checker.sv
// testbench: directed scenarios for the exchange checker
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin failures++; \
	$display("[FAIL] %s exp %h got %h", nm, e, a); end end
module tb_disk_link_exchange_checker;
	logic clk = 1'b0, rst = 1'b0, cmd_sent = 1'b0, cmd_is_seek = 1'b0, init_sent = 1'b0;
	logic rw_ready = 1'b1, pulse_err = 1'b0, go = 1'b0, bad = 1'b0, run = 1'b1;
	logic [1:0] mode = 2'h0;
	logic [4:0] nfr = 5'h00;
	logic [dlx_pkg::ERR_W-1:0] err_clear = '0, err_flags;
	logic drive_clk, drive_rdy, ctrl_rdy, action_stb, drive_dead;
	dlx_pkg::dlx_frame_t frame_in;
	dlx_pkg::dlx_action_t action;
	int failures = 0, checks = 0, cycles = 0, stbs = 0;
	always #2.5 clk = ~clk;
	dlx_drive_model u_drv (.rst(rst), .go(go), .mode(mode), .nfr(nfr), .bad(bad), .run(run),
		.drive_clk(drive_clk), .drive_rdy(drive_rdy), .frame_in(frame_in));
	// short counts keep the run small
	dlx_checker #(.EXCH_TIMEOUT(400), .CLK_WAIT(100)) u_dut (.clk(clk), .rst(rst),
		.drive_clk(drive_clk), .cmd_sent(cmd_sent), .cmd_is_seek(cmd_is_seek),
		.init_sent(init_sent), .drive_rdy(drive_rdy), .rw_ready(rw_ready),
		.pulse_err(pulse_err), .frame_in(frame_in), .err_clear(err_clear), .ctrl_rdy(ctrl_rdy),
		.err_flags(err_flags), .action(action), .action_stb(action_stb), .drive_dead(drive_dead));
	// ====
	// helpers
	function automatic logic [dlx_pkg::ERR_W-1:0] bm(input int b);
		bm = '0;
		bm[b] = 1'b1;
	endfunction : bm
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task automatic end_sim;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : end_sim
	task automatic clr;
		err_clear = '1;
		cyc(1);
		err_clear = '0;
		cyc(1);
		`CHK("cleared", bm(0) & '0, err_flags)
	endtask : clr
	task automatic xchg(input logic [1:0] m, input logic [4:0] n, input logic b, input logic s);
		mode = m;
		nfr = n;
		bad = b;
		cmd_is_seek = s;
		cmd_sent = 1'b1;
		go = 1'b1;
		cyc(1);
		cmd_sent = 1'b0;
		`CHK("ctrl_rdy", 1'b1, ctrl_rdy)
		for (int i = 0; i < 1000 && ctrl_rdy === 1'b1; i++) cyc(1);
		`CHK("released", 1'b0, ctrl_rdy)
		go = 1'b0;
		cyc(s ? 440 : 40);
	endtask : xchg
	task automatic initz(input logic stop, input int hold);
		init_sent = 1'b1;
		cyc(1);
		init_sent = 1'b0;
		run = !stop;
		cyc(hold);
		run = 1'b1;
		cyc(40);
	endtask : initz
	// ====
	// scenarios
	task automatic t_faults;
		int s0;
		xchg(2'h0, 5'h03, 1'b0, 1'b0);
		xchg(2'h0, 5'h02, 1'b0, 1'b1);
		`CHK("clean", bm(0) & '0, err_flags)
		xchg(2'h0, 5'h02, 1'b1, 1'b0);
		`CHK("lenop", bm(dlx_pkg::ERR_LENOP), err_flags)
		`CHK("act", dlx_pkg::DLX_ACT_QUERY, action)
		clr;
		xchg(2'h0, 5'h01, 1'b0, 1'b0);
		xchg(2'h0, 5'h11, 1'b0, 1'b0);
		`CHK("overflow", bm(dlx_pkg::ERR_OVERFLOW), err_flags)
		clr;
		xchg(2'h0, 5'h01, 1'b0, 1'b0);
		xchg(2'h1, 5'h00, 1'b0, 1'b0);
		`CHK("nodrop", bm(dlx_pkg::ERR_COLLIDE), err_flags)
		`CHK("act", dlx_pkg::DLX_ACT_QUERY, action)
		clr;
		xchg(2'h0, 5'h01, 1'b0, 1'b0);
		xchg(2'h0, 5'h00, 1'b0, 1'b0);
		`CHK("early", bm(dlx_pkg::ERR_COLLIDE), err_flags)
		clr;
		xchg(2'h0, 5'h01, 1'b0, 1'b0);
		s0 = stbs;
		pulse_err = 1'b1;
		cyc(4);
		pulse_err = 1'b0;
		cyc(8);
		`CHK("pulse", bm(dlx_pkg::ERR_PULSE), err_flags)
		`CHK("one action", s0 + 1, stbs)
		clr;
	endtask : t_faults
	task automatic t_clock;
		initz(1'b0, 130);
		`CHK("persist", bm(dlx_pkg::ERR_CLK_PERSIST), err_flags)
		clr;
		initz(1'b1, 150);
		`CHK("resume ok", bm(0) & '0, err_flags)
		initz(1'b1, 320);
		`CHK("resume", bm(dlx_pkg::ERR_CLK_RESUME), err_flags)
		clr;
		initz(1'b1, 150);
	endtask : t_clock
	task automatic t_dead;
		rw_ready = 1'b0;
		for (int i = 0; i < 4; i++) begin
			xchg((i == 0) ? 2'h0 : 2'h2, 5'h02, 1'b0, i == 0);
			`CHK("timeout", bm(dlx_pkg::ERR_TIMEOUT), err_flags)
			`CHK("act", (i < 3) ? dlx_pkg::DLX_ACT_INIT : dlx_pkg::DLX_ACT_DEAD, action)
			clr;
			if (i < 3) initz(1'b1, 150);
		end
		`CHK("dead", 1'b1, drive_dead)
		cmd_sent = 1'b1;
		cyc(1);
		cmd_sent = 1'b0;
		cyc(2);
		`CHK("refused", 1'b0, ctrl_rdy)
	endtask : t_dead
	initial begin
		// a real reset edge, so the link flops clear before the drive clock first rises
		#1 rst = 1'b1;
		cyc(4);
		rst = 1'b0;
		cyc(60);
		t_faults;
		t_clock;
		t_dead;
		end_sim;
	end
	always @(posedge clk) begin
		cycles++;
		if (action_stb === 1'b1) stbs++;
		if (cycles == 30000) begin
			failures++;
			end_sim;
		end
	end
endmodule : tb_disk_link_exchange_checker
`default_nettype wire
